// file: sim/tas_far_mdl.sv
// Far-end serial device model: captures frames and answers on its data out
`timescale 1ns/100ps
`default_nettype none

module tas_far_mdl
    import tas_pkg::*;
(
    // Serial pins
    input  wire logic             sclk,
    input  wire logic             sen_n,
    input  wire logic             sdi,
    output logic                  sdo,
    // Words
    input  wire logic [SER_W-1:0] tx_word,
    output logic      [SER_W-1:0] rx_word
);
    logic [SER_W-1:0] sh;

    // Deselected line shows the inverse, so a stale bit never passes for data
    assign sdo = sen_n ? ~sh[SER_W-1] : sh[SER_W-1];
    always @(negedge sen_n) sh = tx_word;
    always @(negedge sclk) if (!sen_n) sh = sh << 1;
    always @(posedge sclk) if (!sen_n) rx_word = {rx_word[SER_W-2:0], sdi};
endmodule : tas_far_mdl

`default_nettype wire

// file: sim/tas_sup_chk.sv
// Concurrent checks on the supervisor top ports
`timescale 1ns/100ps
`default_nettype none

module tas_sup_chk
    import tas_pkg::*;
#(
    parameter int RAMP_CYC    = RAMP_CYCLES,
    parameter int REFRESH_CYC = REFRESH_CYCLES
)(
    // Clock and reset
    input wire logic                        ref_clk,
    input wire logic                        resetn,
    // Inputs watched
    input wire logic [NUM_LINES-1:0]        alarm_lines,
    input wire logic [NUM_RD-1:0][RD_W-1:0] readings,
    input wire logic [NUM_RD-1:0][RD_W-1:0] nominal_lo,
    input wire logic [NUM_RD-1:0][RD_W-1:0] nominal_hi,
    input wire logic [RD_W-1:0]             rev_limit,
    input wire logic                        clear_history_key,
    input wire logic                        term_valid,
    input wire logic [7:0]                  term_byte,
    // Outputs watched
    input wire logic [NUM_ALM-1:0]          alarm_active,
    input wire logic [NUM_ALM-1:0]          alarm_past,
    input wire logic                        tx_enable,
    input wire logic                        ramp_done,
    input wire logic [ALC_W-1:0]            alc_ref,
    input wire logic                        syn_sen_n
);
    localparam int STP = (RAMP_CYC / RAMP_STEPS > 0) ? RAMP_CYC / RAMP_STEPS : 1;
    int   en_cnt, lo_cnt, id_cnt;
    logic clr;

    // ==========================================
    // Helper counters
    assign clr = clear_history_key || (term_valid && term_byte == TERM_CLEAR_CHAR);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            en_cnt <= 0;
            lo_cnt <= 0;
            id_cnt <= 0;
        end else begin
            en_cnt <= tx_enable ? en_cnt + 1 : 0;
            lo_cnt <= syn_sen_n ? 0 : lo_cnt + 1;
            id_cnt <= syn_sen_n ? id_cnt + 1 : 0;
        end
    end

    // ==========================================
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_REV: assert property (
        readings[RD_REV] > rev_limit |=> alarm_active[NUM_LINES+RD_REV] && alc_ref == '0)
        else $error("reverse power alarm missing");
    AST_WIN: assert property (
        readings[RD_CUR] > nominal_hi[RD_CUR] || readings[RD_CUR] < nominal_lo[RD_CUR]
        |=> alarm_active[NUM_LINES+RD_CUR]) else $error("window alarm missing");
    AST_CUT: assert property (
        (alarm_active & ALM_INHIBIT_MASK) != '0 |-> alc_ref == '0 && !tx_enable)
        else $error("power not cut during alarm");
    AST_LOCK: assert property (
        !alarm_lines[LN_LOCK] [*8] |=> alarm_active[LN_LOCK] && !tx_enable)
        else $error("lock alarm missing");
    AST_DEB: assert property (
        $past(resetn, 8) && $rose(alarm_active[LN_TEMP])
        |-> !$past(alarm_lines[LN_TEMP], 3) && !$past(alarm_lines[LN_TEMP], 5))
        else $error("alarm raised without debounce");
    AST_PAST: assert property (
        $fell(alarm_active[NUM_LINES+RD_P9]) |-> ##[0:1] alarm_past[NUM_LINES+RD_P9])
        else $error("past mark not set");
    AST_CLR: assert property (
        clr |=> alarm_past == ($past(alarm_active) & ~alarm_active))
        else $error("past marks not erased");
    AST_RAMP: assert property (
        $rose(ramp_done) |-> en_cnt >= 4095 * STP - 8 && en_cnt <= 4095 * STP + 8)
        else $error("ramp length wrong");
    AST_FRAME: assert property (
        $rose(syn_sen_n) |-> lo_cnt >= 1200 && lo_cnt <= 1320)
        else $error("synthesizer frame length wrong");
    AST_RFSH: assert property (
        syn_sen_n |-> id_cnt <= REFRESH_CYC + 40) else $error("synthesizer not refreshed");

    COV_RAMP: cover property ($rose(ramp_done));
    COV_FRAME: cover property ($rose(syn_sen_n));
    COV_CLR: cover property (clr && alarm_past != '0);
endmodule : tas_sup_chk

bind tas_supervisor tas_sup_chk #(.RAMP_CYC(RAMP_CYC), .REFRESH_CYC(REFRESH_CYC)) u_chk (.*);

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the transmitter alarm supervisor
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import tas_pkg::*;
    logic                        ref_clk, resetn, clear_history_key, term_valid, mod_miso;
    logic                        kp_power_wr, kp_channel_wr, kp_mod_wr, term_power_wr;
    logic                        term_channel_wr, term_mod_wr, tx_enable, ramp_done;
    logic                        syn_sclk, syn_sdata, syn_sen_n, mod_sclk, mod_mosi, mod_sen_n;
    logic [NUM_LINES-1:0]        alarm_lines;
    logic [NUM_RD-1:0][RD_W-1:0] readings, nominal_lo, nominal_hi;
    logic [RD_W-1:0]             rev_limit;
    logic [ALC_W-1:0]            kp_power, term_power, alc_ref, pw;
    logic [CH_W-1:0]             kp_channel, term_channel;
    logic [CFG_W-1:0]            kp_pilot, kp_usb_rej, term_pilot, term_usb_rej;
    logic [7:0]                  term_byte;
    logic [NUM_ALM-1:0]          alarm_active, alarm_past, m_past;
    logic [SER_W-1:0]            mod_status, mod_tx, syn_rx, mod_rx;
    logic [63:0]                 rv;
    logic [47:0]                 ew;
    int                          seed, error_cnt, cmp_count, n;

    tas_supervisor #(.RAMP_CYC(4096), .DEB_CYC(4), .REFRESH_CYC(3000)) i_dut (.*);
    tas_far_mdl i_syn (.sclk(syn_sclk), .sen_n(syn_sen_n), .sdi(syn_sdata), .sdo(),
                       .tx_word(24'h000000), .rx_word(syn_rx));
    tas_far_mdl i_mod (.sclk(mod_sclk), .sen_n(mod_sen_n), .sdi(mod_mosi), .sdo(mod_miso),
                       .tx_word(mod_tx), .rx_word(mod_rx));

    // ==========================================
    // Tasks
    task automatic step(input int c);
        repeat (c) @(negedge ref_clk);
    endtask : step

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test

    // A wait that runs out ends the run at once
    task automatic tmo(input int c);
        if (c >= 5000) begin
            chk("wait_done", 32'h0, 32'h1);
            end_of_test();
        end
    endtask : tmo

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ==========================================
    // Main sequence
    initial begin
        {seed, error_cnt, cmp_count} = {32'd38, 32'd0, 32'd0};
        resetn = 1'b0;
        alarm_lines = '1;
        {clear_history_key, term_valid, kp_power_wr, kp_channel_wr, kp_mod_wr} = '0;
        {term_power_wr, term_channel_wr, term_mod_wr, mod_tx, term_byte} = '0;
        {kp_power, term_power, kp_channel, term_channel} = '0;
        {kp_pilot, kp_usb_rej, term_pilot, term_usb_rej} = '0;
        rev_limit = 12'h400;
        for (int r = 0; r < NUM_RD; r++) begin
            nominal_lo[r] = 12'h100;
            nominal_hi[r] = 12'h700;
            readings[r] = r == RD_REV ? 12'h100 : 12'h400;
        end
        step(12);
        resetn = 1'b1;
        step(20);
        chk("alarm_active", alarm_active, 0);
        chk("alarm_past", alarm_past, 13'h003f);
        term_byte = 8'h31;
        term_valid = 1'b1;
        step(1);
        term_valid = 1'b0;
        step(1);
        chk("alarm_past", alarm_past, 0);
        m_past = '0;
        alarm_lines[LN_SYNC] = 1'b0;
        step(3);
        alarm_lines = '1;
        step(10);
        chk("alarm_active", alarm_active, 0);
        for (int k = 0; k < 2; k++) begin
            pw = $random(seed);
            {kp_power, term_power} = {pw, pw};
            {kp_power_wr, term_power_wr} = k ? 2'b01 : 2'b10;
            step(1);
            {kp_power_wr, term_power_wr} = 2'b00;
            for (n = 0; n < 5000 && ramp_done !== 1'b1; n++) step(1);
            tmo(n);
            step(2);
            chk("alc_ref", alc_ref, pw);
        end
        for (int i = 0; i < NUM_LINES; i++) begin
            alarm_lines[i] = 1'b0;
            step(10);
            chk("alarm_active", alarm_active, 13'h0001 << i);
            chk("alc_ref", alc_ref, 0);
            alarm_lines = '1;
            step(12);
            m_past[i] = 1'b1;
            chk("alarm_past", alarm_past, m_past);
            chk("tx_enable", tx_enable, 1);
        end
        for (int r = 0; r < NUM_RD; r++) begin
            readings[r] = r == RD_REV ? rev_limit + 12'h001 : nominal_hi[r] + 12'h001;
            step(2);
            chk("alarm_active", alarm_active, 13'h0001 << (NUM_LINES + r));
            chk("tx_enable", tx_enable, r != RD_REV);
            readings[r] = r == RD_REV ? 12'h100 : 12'h400;
            step(2);
            m_past[NUM_LINES + r] = 1'b1;
            chk("alarm_past", alarm_past, m_past);
            if (r == RD_REV) chk("alc_ref", alc_ref, 0);
        end
        clear_history_key = 1'b1;
        step(1);
        clear_history_key = 1'b0;
        step(1);
        chk("alarm_past", alarm_past, 0);
        for (int k = 0; k < 2; k++) begin
            rv = {$random(seed), $random(seed)};
            mod_tx = rv[63:40];
            {kp_channel, kp_pilot, kp_usb_rej} = rv[39:0];
            {term_channel, term_pilot, term_usb_rej} = rv[39:0];
            ew = {rv[39:16], MOD_CMD_CFG, rv[15:0]};
            {kp_channel_wr, kp_mod_wr, term_channel_wr, term_mod_wr} = k ? 4'h3 : 4'hc;
            step(1);
            {kp_channel_wr, kp_mod_wr, term_channel_wr, term_mod_wr} = 4'h0;
            for (n = 0; n < 5000 && {syn_rx, mod_rx} !== ew; n++) step(1);
            tmo(n);
            chk("syn_rx", syn_rx, ew[47:24]);
            chk("mod_rx", mod_rx, ew[23:0]);
            for (n = 0; n < 5000 && mod_sen_n !== 1'b1; n++) step(1);
            tmo(n);
            step(2);
            chk("mod_status", mod_status, mod_tx);
        end
        end_of_test();
    end
endmodule : testbench

`default_nettype wire

// file: src/tas_pkg.sv
// Shared constants and types for the transmitter alarm supervisor
package tas_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int RAMP_TIME_S     = 5;
    localparam int RAMP_CYCLES     = RAMP_TIME_S * CLK_HZ;
    localparam int DEB_TIME_US     = 1000;
    localparam int DEB_CYCLES      = DEB_TIME_US * (CLK_HZ / 1_000_000);
    localparam int REFRESH_TIME_MS = 100;
    localparam int REFRESH_CYCLES  = REFRESH_TIME_MS * (CLK_HZ / 1000);
    localparam int SER_RATE_HZ     = 1_000_000;
    localparam int SER_HALF_CYCLES = CLK_HZ / (2 * SER_RATE_HZ);

    // ==========================================================
    // Widths and counts
    localparam int RD_W      = 12;
    localparam int ALC_W     = 12;
    localparam int SER_W     = 24;
    localparam int CH_W      = 24;
    localparam int CFG_W     = 8;
    localparam int NUM_LINES = 6;
    localparam int NUM_RD    = 7;
    localparam int NUM_ALM   = NUM_LINES + NUM_RD;
    localparam int FRAC_W    = 12;
    localparam int RAMP_STEPS = 4096;

    // ==========================================================
    // Alarm line positions (all lines high when healthy)
    localparam int LN_LOCK   = 0;
    localparam int LN_TEMP   = 1;
    localparam int LN_FIFO   = 2;
    localparam int LN_SYNC   = 3;
    localparam int LN_UNPROG = 4;
    localparam int LN_MCLK   = 5;

    // Reading positions; alarm bit of reading r is NUM_LINES + r
    localparam int RD_FWD = 0;
    localparam int RD_REV = 1;
    localparam int RD_P9  = 2;
    localparam int RD_P18 = 3;
    localparam int RD_N18 = 4;
    localparam int RD_P32 = 5;
    localparam int RD_CUR = 6;

    // Alarms that cut transmission: all lines plus reverse power
    localparam logic [NUM_ALM-1:0] ALM_INHIBIT_MASK = 13'h00bf;

    // ==========================================================
    // Codes and reset values
    localparam logic [7:0]       TERM_CLEAR_CHAR = 8'h31;
    localparam logic [7:0]       MOD_CMD_CFG     = 8'h01;
    localparam logic [ALC_W-1:0] POWER_RST       = 12'h000;
    localparam logic [CH_W-1:0]  CHANNEL_RST     = 24'h000000;
    localparam logic [CFG_W-1:0] PILOT_RST       = 8'h00;
    localparam logic [CFG_W-1:0] USB_REJ_RST     = 8'h00;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_LEAD  = 2'b01,
        SER_SHIFT = 2'b11,
        SER_TAIL  = 2'b10
    } tas_ser_state_t;

endpackage : tas_pkg

// file: src/tas_ser_if.sv
// Request and pin bundle between supervisor core and serial shifter
`timescale 1ns/100ps
`default_nettype none

interface tas_ser_if;
    import tas_pkg::*;
    logic             start;
    logic [SER_W-1:0] word;
    logic             busy;
    logic             done;
    logic [SER_W-1:0] rx_word;
    logic             sclk;
    logic             sdata;
    logic             sen_n;
    logic             miso;

    modport ctl (output start, word, miso,
                 input  busy, done, rx_word, sclk, sdata, sen_n);
    modport shf (input  start, word, miso,
                 output busy, done, rx_word, sclk, sdata, sen_n);
endinterface : tas_ser_if

`default_nettype wire

// file: src/tas_ser_shift.sv
// Serial shifter: data, clock and enable out, readback in
`timescale 1ns/100ps
`default_nettype none

module tas_ser_shift
    import tas_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Request side and pins
    tas_ser_if.shf    s
);

    typedef struct packed {
        tas_ser_state_t   st;
        logic [7:0]       div;
        logic [4:0]       bits;
        logic [SER_W-1:0] sh;
        logic [SER_W-1:0] rx;
        logic             sclk;
        logic             sen_n;
        logic             busy;
        logic             done;
    } tas_shf_st_t;

    localparam tas_shf_st_t SHF_RST = '{st: SER_IDLE, sen_n: 1'b1, default: '0};

    tas_shf_st_t q;
    tas_shf_st_t d;
    logic        tick;

    // ==========================================================
    // Next state
    always_comb begin
        d      = q;
        d.done = 1'b0;
        tick   = (q.div == 8'(SER_HALF_CYCLES - 1));
        if (q.st != SER_IDLE) begin
            d.div = tick ? 8'h00 : q.div + 8'h01;
        end
        case (q.st)
            SER_IDLE: begin
                if (s.start) begin
                    d.sh    = s.word;
                    d.rx    = '0;
                    d.sen_n = 1'b0;
                    d.busy  = 1'b1;
                    d.bits  = 5'(SER_W - 1);
                    d.div   = 8'h00;
                    d.st    = SER_LEAD;
                end
            end
            SER_LEAD: begin
                if (tick) begin
                    d.st = SER_SHIFT;
                end
            end
            SER_SHIFT: begin
                if (tick) begin
                    if (!q.sclk) begin
                        // Far end samples on the rising edge; so do we
                        d.sclk = 1'b1;
                        d.rx   = {q.rx[SER_W-2:0], s.miso};
                    end else begin
                        d.sclk = 1'b0;
                        if (q.bits == 5'h00) begin
                            d.st = SER_TAIL;
                        end else begin
                            d.sh   = {q.sh[SER_W-2:0], 1'b0};
                            d.bits = q.bits - 5'h01;
                        end
                    end
                end
            end
            SER_TAIL: begin
                if (tick) begin
                    d.sen_n = 1'b1;
                    d.busy  = 1'b0;
                    d.done  = 1'b1;
                    d.st    = SER_IDLE;
                end
            end
            default: begin
                d = SHF_RST;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= SHF_RST;
        end else begin
            q <= d;
        end
    end

    assign s.busy    = q.busy;
    assign s.done    = q.done;
    assign s.rx_word = q.rx;
    assign s.sclk    = q.sclk;
    assign s.sdata   = q.sh[SER_W-1];
    assign s.sen_n   = q.sen_n;

endmodule : tas_ser_shift

`default_nettype wire

// file: src/tas_supervisor.sv
// Transmitter alarm supervisor: alarms, power cut, slope-up, serial control
//
// Overview of operation
// - Each reading other than reverse power outside its nominal low/high window raises its own alarm.
// - Reverse power reading above calibrated limit is an alarm.
// - Any line alarm or the reverse power alarm forces the level-control reference to zero; window alarms do not.
// - Lock, temperature, reverse power, FIFO, sync, unprogrammed, clock alarms recognised.
// - Amplifier over-temperature report raises the temperature alarm.
// - Active line or reverse power alarm cuts transmission at once and holds it off meanwhile.
// - Cleared cause turns alarm to past; transmission resumes by itself.
// - Clear key or terminal character 1 erases all past alarms.
// - Missing synthesizer lock indication raises lock alarm and zeroes power.
// - Channel code goes to synthesizer over data, clock, enable lines.
// - Synthesizer is reprogrammed periodically, not only once.
// - Modulator pilot and sideband settings written and status read over SPI.
// - Level reference rises monotonically with programmed power.
// - Reference ramps from zero to target over about five seconds.
// - Every keypad setting is also accepted from the terminal.
`timescale 1ns/100ps
`default_nettype none

module tas_supervisor
    import tas_pkg::*;
#(
    parameter int RAMP_CYC    = RAMP_CYCLES,
    parameter int DEB_CYC     = DEB_CYCLES,
    parameter int REFRESH_CYC = REFRESH_CYCLES
)(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    // Alarm lines, high when healthy
    input  wire logic [NUM_LINES-1:0]        alarm_lines,
    // Digitised monitor readings and their nominal windows
    input  wire logic [NUM_RD-1:0][RD_W-1:0] readings,
    input  wire logic [NUM_RD-1:0][RD_W-1:0] nominal_lo,
    input  wire logic [NUM_RD-1:0][RD_W-1:0] nominal_hi,
    input  wire logic [RD_W-1:0]             rev_limit,
    // Keypad
    input  wire logic                        clear_history_key,
    input  wire logic                        kp_power_wr,
    input  wire logic [ALC_W-1:0]            kp_power,
    input  wire logic                        kp_channel_wr,
    input  wire logic [CH_W-1:0]             kp_channel,
    input  wire logic                        kp_mod_wr,
    input  wire logic [CFG_W-1:0]            kp_pilot,
    input  wire logic [CFG_W-1:0]            kp_usb_rej,
    // Serial terminal, one received byte per strobe
    input  wire logic                        term_valid,
    input  wire logic [7:0]                  term_byte,
    input  wire logic                        term_power_wr,
    input  wire logic [ALC_W-1:0]            term_power,
    input  wire logic                        term_channel_wr,
    input  wire logic [CH_W-1:0]             term_channel,
    input  wire logic                        term_mod_wr,
    input  wire logic [CFG_W-1:0]            term_pilot,
    input  wire logic [CFG_W-1:0]            term_usb_rej,
    // Status for display
    output logic      [NUM_ALM-1:0]          alarm_active,
    output logic      [NUM_ALM-1:0]          alarm_past,
    output logic                             tx_enable,
    output logic                             ramp_done,
    output logic      [SER_W-1:0]            mod_status,
    // Level-control reference to up-converter
    output logic      [ALC_W-1:0]            alc_ref,
    // Synthesizer programming pins
    output logic                             syn_sclk,
    output logic                             syn_sdata,
    output logic                             syn_sen_n,
    // Modulator SPI pins
    output logic                             mod_sclk,
    output logic                             mod_mosi,
    output logic                             mod_sen_n,
    input  wire logic                        mod_miso
);

    localparam int STEP_RAW = RAMP_CYC / RAMP_STEPS;
    localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;
    localparam logic [FRAC_W-1:0] FRAC_MAX = '1;

    typedef struct packed {
        logic [NUM_LINES-1:0]         sync1;
        logic [NUM_LINES-1:0]         sync2;
        logic [NUM_LINES-1:0]         stable;
        logic [NUM_LINES-1:0][31:0]   deb_cnt;
        logic [NUM_ALM-1:0]           active;
        logic [NUM_ALM-1:0]           past;
        logic [ALC_W-1:0]             target;
        logic [CH_W-1:0]              channel;
        logic [CFG_W-1:0]             pilot;
        logic [CFG_W-1:0]             usb_rej;
        logic [FRAC_W-1:0]            frac;
        logic [31:0]                  step_cnt;
        logic [ALC_W-1:0]             alc;
        logic                         tx_on;
        logic                         ramp_done;
        logic [31:0]                  refresh_cnt;
        logic                         syn_pend;
        logic                         mod_pend;
        logic                         syn_start;
        logic                         mod_start;
        logic [SER_W-1:0]             mod_status;
    } tas_sup_st_t;

    // Lines start as alarmed so power waits for a clean debounce
    localparam tas_sup_st_t SUP_RST = '{
        target:  POWER_RST,
        channel: CHANNEL_RST,
        pilot:   PILOT_RST,
        usb_rej: USB_REJ_RST,
        syn_pend: 1'b1,
        mod_pend: 1'b1,
        default: '0
    };

    tas_sup_st_t q;
    tas_sup_st_t d;

    tas_ser_if syn_if ();
    tas_ser_if mod_if ();

    logic [NUM_ALM-1:0]       cause;
    logic                     clr_req;
    logic                     inhibit;
    logic [ALC_W+FRAC_W-1:0]  scaled;

    function automatic logic out_of_window(input logic [RD_W-1:0] v,
                                           input logic [RD_W-1:0] lo,
                                           input logic [RD_W-1:0] hi);
        out_of_window = (v < lo) || (v > hi);
    endfunction : out_of_window

    // ==========================================================
    // Next state
    always_comb begin
        d           = q;
        d.syn_start = 1'b0;
        d.mod_start = 1'b0;

        // Keypad wins when both sources write in one cycle
        if (kp_power_wr) begin
            d.target = kp_power;
        end else if (term_power_wr) begin
            d.target = term_power;
        end
        if (kp_channel_wr) begin
            d.channel  = kp_channel;
            d.syn_pend = 1'b1;
        end else if (term_channel_wr) begin
            d.channel  = term_channel;
            d.syn_pend = 1'b1;
        end
        if (kp_mod_wr) begin
            d.pilot    = kp_pilot;
            d.usb_rej  = kp_usb_rej;
            d.mod_pend = 1'b1;
        end else if (term_mod_wr) begin
            d.pilot    = term_pilot;
            d.usb_rej  = term_usb_rej;
            d.mod_pend = 1'b1;
        end

        // Two-stage sync, then a line must hold its new level
        d.sync1 = alarm_lines;
        d.sync2 = q.sync1;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (q.sync2[i] == q.stable[i]) begin
                d.deb_cnt[i] = '0;
            end else if (q.deb_cnt[i] == 32'(DEB_CYC - 1)) begin
                d.stable[i]  = q.sync2[i];
                d.deb_cnt[i] = '0;
            end else begin
                d.deb_cnt[i] = q.deb_cnt[i] + 32'd1;
            end
        end

        // Low line is an alarm: lock, temperature and the rest
        cause = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            cause[i] = ~q.stable[i];
        end
        for (int r = 0; r < NUM_RD; r++) begin
            if (r == RD_REV) begin
                cause[NUM_LINES + r] = (readings[r] > rev_limit);
            end else begin
                cause[NUM_LINES + r] = out_of_window(readings[r],
                                                     nominal_lo[r],
                                                     nominal_hi[r]);
            end
        end
        d.active = cause;

        // A cause that ends in the clear cycle still leaves a past mark
        clr_req = clear_history_key ||
                  (term_valid && (term_byte == TERM_CLEAR_CHAR));
        d.past  = (q.past & ~{NUM_ALM{clr_req}})
                | (q.active & ~cause);

        // Cut acts on the raw cause, in the same cycle as the display
        inhibit = |(cause & ALM_INHIBIT_MASK);
        d.tx_on = ~inhibit;

        // Fraction of target advances in equal steps
        scaled = q.target * q.frac;

        if (inhibit) begin
            d.frac      = '0;
            d.step_cnt  = '0;
            d.alc       = '0;
            d.ramp_done = 1'b0;
        end else begin
            if (q.frac != FRAC_MAX) begin
                if (q.step_cnt == 32'(STEP_CYC - 1)) begin
                    d.step_cnt = '0;
                    d.frac     = q.frac + 12'h001;
                end else begin
                    d.step_cnt = q.step_cnt + 32'd1;
                end
            end
            d.ramp_done = (q.frac == FRAC_MAX);
            // Full fraction hands the exact setting straight through
            if (q.frac == FRAC_MAX) begin
                d.alc = q.target;
            end else begin
                d.alc = scaled[ALC_W+FRAC_W-1:FRAC_W];
            end
        end

        // Periodic re-send keeps the synthesizer and modulator in step
        if (q.refresh_cnt == 32'(REFRESH_CYC - 1)) begin
            d.refresh_cnt = '0;
            d.syn_pend    = 1'b1;
            d.mod_pend    = 1'b1;
        end else begin
            d.refresh_cnt = q.refresh_cnt + 32'd1;
        end

        // busy rises one cycle after start, hence the start guard
        if (q.syn_pend && !syn_if.busy && !q.syn_start) begin
            d.syn_start = 1'b1;
            d.syn_pend  = 1'b0;
        end

        if (q.mod_pend && !mod_if.busy && !q.mod_start) begin
            d.mod_start = 1'b1;
            d.mod_pend  = 1'b0;
        end

        if (mod_if.done) begin
            d.mod_status = mod_if.rx_word;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= SUP_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Serial shifters
    assign syn_if.start = q.syn_start;
    assign syn_if.word  = q.channel;
    assign syn_if.miso  = 1'b0;
    assign mod_if.start = q.mod_start;
    assign mod_if.word  = {MOD_CMD_CFG, q.pilot, q.usb_rej};
    assign mod_if.miso  = mod_miso;

    tas_ser_shift u_syn_shift (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .s       (syn_if.shf)
    );

    tas_ser_shift u_mod_shift (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .s       (mod_if.shf)
    );

    // ==========================================================
    // Outputs
    assign alarm_active = q.active;
    assign alarm_past   = q.past;
    assign tx_enable    = q.tx_on;
    assign ramp_done    = q.ramp_done;
    assign mod_status   = q.mod_status;
    assign alc_ref      = q.alc;
    assign syn_sclk     = syn_if.sclk;
    assign syn_sdata    = syn_if.sdata;
    assign syn_sen_n    = syn_if.sen_n;
    assign mod_sclk     = mod_if.sclk;
    assign mod_mosi     = mod_if.sdata;
    assign mod_sen_n    = mod_if.sen_n;

endmodule : tas_supervisor

`default_nettype wire
